// file: verilog/baf_top.v
// Purpose: Buffered-mode decimation filter with group-delay compensation.
// Assumes: adc_valid marks one oversampled word per channel; APB zero-wait.
// Notes:   Overview of operation:
// Overview of operation
// - decimation window follows the programmed sample period, tracking Nyquist.
// - below 25 Hz a shorter window and smaller fixed delay are used.
// - boxcar window puts stopband nulls at fixed multiples of the sample rate.
// - sample clock exported at input instant; its data returned after latency.
// - after a start trigger the next sample clock edge gives the first point.
// - on-demand read samples at maximum rate when no task runs (else at the programmed period) and returns after the group delay.
// - group delay equals fixed term plus 48.5 sample periods.
// - analog input delay of the chosen range is added to the latency.
// - optional per-channel fourth-order lowpass after the decimator.
// - the optional lowpass is bypassed on all channels after reset.
// - every channel holds its own enable and cut-off selection.
// - the optional lowpass delay is not compensated.
//
// The address map and the APB register port were decided locally.
`timescale 1ns/1ps
`default_nettype none
`include "baf_map.vh"

module baf_top #(
    parameter [31:0] FIX_DLY_CYC   = `BAF_FIX_DLY_CYC,
    parameter [31:0] LOOSE_FIX_CYC = `BAF_LOOSE_FIX_CYC
) (
    input  wire                         pclk,
    input  wire                         presetn,
    input  wire                         psel,
    input  wire                         penable,
    input  wire                         pwrite,
    input  wire [7:0]                   paddr,
    input  wire [31:0]                  pwdata,
    output reg  [31:0]                  prdata,
    output wire                         pready,
    output wire                         pslverr,
    input  wire                         adc_valid,
    input  wire [`BAF_NCH*`BAF_DW-1:0]  adc_data,
    input  wire                         start_trig,
    output reg                          samp_clk_out,
    output reg                          trig_out,
    output reg                          out_valid,
    output reg                          out_first,
    output reg  [`BAF_NCH*`BAF_DW-1:0]  out_data
);
    localparam NW = `BAF_NCH * `BAF_DW;
    localparam [23:0] MAX_PER   = `BAF_MAX_PERIOD;
    localparam [23:0] LOOSE_PER = `BAF_LOOSE_PERIOD;
    localparam [31:0] AIN_10V   = `BAF_AIN_10V_CYC;
    localparam [31:0] AIN_OTH   = `BAF_AIN_OTH_CYC;
    localparam [31:0] HALF_NUM  = `BAF_HALF_SMP_NUM;

    // ======================================================================
    // Helpers
    function signed [31:0] sext;
        input [`BAF_DW-1:0] v;
        begin
            sext = {{(32-`BAF_DW){v[`BAF_DW-1]}}, v};
        end
    endfunction

    function [`BAF_DW-1:0] scale;
        input signed [31:0] a;
        input        [4:0]  s;
        reg   signed [31:0] t;
        begin
            t     = a >>> s;
            scale = t[`BAF_DW-1:0];
        end
    endfunction

    function [`BAF_DW-1:0] lane;
        input [NW-1:0] bus;
        input integer  ch;
        begin
            lane = bus[ch*`BAF_DW +: `BAF_DW];
        end
    endfunction

    // ======================================================================
    // Register state
    reg                 en_q, arm_q, trig_q, first_pend_q;
    reg                 od_busy_q, od_tagged_q, od_done_q, ovr_q;
    reg  [23:0]         period_q;
    reg  [4:0]          shift_q;
    reg  [1:0]          range_q;
    reg  [`BAF_NCH-1:0] fen_q;
    reg  [2*`BAF_NCH-1:0] fsel_q;
    reg  [NW-1:0]       od_data_q;
    reg  [31:0]         lat_q;

    wire wr_acc  = psel & penable & pwrite;
    wire setup   = psel & ~penable;
    wire mapped  = (paddr[1:0] == 2'h0) && (paddr <= `BAF_OD_DATA_LAST);
    assign pready  = 1'b1;
    assign pslverr = psel & penable & ~mapped;
    wire wr_ok   = wr_acc & mapped;
    wire od_req  = wr_ok && paddr == `BAF_OFF_CTRL && pwdata[`BAF_CTRL_OD_REQ];
    wire clr_st  = wr_ok && paddr == `BAF_OFF_STATUS;

    // ======================================================================
    // Sample timing
    // The on-demand path borrows the converter at full rate when no task runs.
    wire        running = en_q | od_busy_q;
    wire [23:0] per_eff = (od_busy_q & ~en_q) ? MAX_PER : period_q;
    wire        loose   = per_eff > LOOSE_PER;
    reg  [23:0] cnt_q;
    wire        tick    = running && (cnt_q >= per_eff - 24'h1);
    wire        half    = loose && (cnt_q == {1'b0, per_eff[23:1]});

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_q <= 24'h0;
        end else begin
            cnt_q <= (!running || tick) ? 24'h0 : cnt_q + 24'h1;
        end
    end

    // ======================================================================
    // Decimator
    // A boxcar over one sample period nulls multiples of the rate; in loose mode it spans half a period and nulls even multiples.
    reg signed [31:0]    acc_q [0:`BAF_NCH-1];
    reg [`BAF_DW-1:0]    dec_q [0:`BAF_NCH-1];
    reg                  dec_stb_q;
    integer              c;

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (c = 0; c < `BAF_NCH; c = c + 1) begin
                acc_q[c] <= 32'h0;
                dec_q[c] <= {`BAF_DW{1'b0}};
            end
            dec_stb_q <= 1'b0;
        end else begin
            dec_stb_q <= tick;
            for (c = 0; c < `BAF_NCH; c = c + 1) begin
                if (tick) begin
                    dec_q[c] <= scale(acc_q[c], shift_q);
                    acc_q[c] <= adc_valid ? sext(lane(adc_data, c)) : 32'h0;
                end else if (half || !running) begin
                    acc_q[c] <= adc_valid ? sext(lane(adc_data, c)) : 32'h0;
                end else if (adc_valid) begin
                    acc_q[c] <= acc_q[c] + sext(lane(adc_data, c));
                end
            end
        end
    end

    // ======================================================================
    // Optional lowpass stages
    wire [`BAF_DW-1:0]   iir_y [0:`BAF_NCH-1];
    wire [`BAF_NCH-1:0]  iir_stb;
    genvar g;
    generate
        for (g = 0; g < `BAF_NCH; g = g + 1) begin : g_iir
            baf_iir u_iir (
                .pclk    (pclk),
                .presetn (presetn),
                .stb     (dec_stb_q),
                .en      (fen_q[g]),
                .sel     (fsel_q[2*g +: 2]),
                .x       (dec_q[g]),
                .y_q     (iir_y[g]),
                .ystb_q  (iir_stb[g])
            );
        end
    endgenerate

    // ======================================================================
    // Latency
    // The lowpass stage delay is frequency dependent and left uncorrected.
    wire [31:0] prod = {8'h0, per_eff} * HALF_NUM;
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lat_q <= 32'h0;
        end else begin
            lat_q <= (loose ? LOOSE_FIX_CYC : FIX_DLY_CYC) + {1'b0, prod[31:1]}
                   + ((range_q == 2'h0) ? AIN_10V : AIN_OTH);
        end
    end

    // ======================================================================
    // Trigger alignment and release ring
    // Depth limits latency to 64 sample periods; beyond that overrun is flagged.
    reg  [NW+2:0]             ring_q [0:(1<<`BAF_RING_AW)-1];
    reg  [`BAF_RING_AW:0]     wp_q, rp_q;
    reg  [2:0]                tag_q;
    reg                       rel_run_q;
    reg  [31:0]               rel_cnt_q;
    wire [`BAF_RING_AW:0]     pend = wp_q - rp_q;
    wire                      release_now = rel_run_q && rel_cnt_q == 32'h0 && pend != 0;
    wire [NW+2:0]             head = ring_q[rp_q[`BAF_RING_AW-1:0]];
    wire                      ret  = trig_q & en_q;
    wire                      od_rel = release_now & head[NW+2];
    reg  [NW-1:0]             wdat;
    integer                   k;

    always @* begin
        wdat = {NW{1'b0}};
        for (k = 0; k < `BAF_NCH; k = k + 1) begin
            wdat[k*`BAF_DW +: `BAF_DW] = iir_y[k];
        end
    end

    always @(posedge pclk) begin
        if (iir_stb[0]) begin
            ring_q[wp_q[`BAF_RING_AW-1:0]] <= {tag_q, wdat};
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wp_q <= {(`BAF_RING_AW+1){1'b0}};
            rp_q <= {(`BAF_RING_AW+1){1'b0}};
            tag_q <= 3'h0;
            rel_run_q <= 1'b0;
            rel_cnt_q <= 32'h0;
            trig_q <= 1'b0;
            first_pend_q <= 1'b0;
            od_tagged_q <= 1'b0;
            samp_clk_out <= 1'b0;
            trig_out <= 1'b0;
            out_valid <= 1'b0;
            out_first <= 1'b0;
            out_data <= {NW{1'b0}};
        end else begin
            if (!en_q) begin
                trig_q <= 1'b0;
            end else if (!trig_q && (!arm_q || start_trig)) begin
                trig_q <= 1'b1;
                first_pend_q <= 1'b1;
            end
            samp_clk_out <= tick & ret;
            trig_out <= tick & ret & first_pend_q;
            if (tick) begin
                tag_q <= {od_busy_q & ~od_tagged_q, ret & first_pend_q, ret};
                if (ret) begin
                    first_pend_q <= 1'b0;
                end
                if (od_busy_q) begin
                    od_tagged_q <= 1'b1;
                end
            end
            if (od_rel) begin
                od_tagged_q <= 1'b0;
            end
            if (iir_stb[0]) begin
                wp_q <= wp_q + 1'b1;
            end
            if (tick && !rel_run_q) begin
                rel_run_q <= 1'b1;
                rel_cnt_q <= lat_q - 32'h1;
            end else if (rel_run_q) begin
                if (rel_cnt_q == 32'h0) begin
                    rel_cnt_q <= {8'h0, per_eff} - 32'h1;
                    if (!running && pend == 0) begin
                        rel_run_q <= 1'b0;
                    end
                end else begin
                    rel_cnt_q <= rel_cnt_q - 32'h1;
                end
            end
            out_valid <= release_now & head[NW];
            out_first <= release_now & head[NW+1];
            if (release_now) begin
                rp_q <= rp_q + 1'b1;
            end
            if (release_now & head[NW]) begin
                out_data <= head[NW-1:0];
            end
        end
    end

    // ======================================================================
    // APB registers
    // Status flags: a hardware set in the clearing cycle wins over the clear.
    wire ovr_set = tick && pend[`BAF_RING_AW];

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            en_q      <= 1'b0;
            arm_q     <= 1'b0;
            period_q  <= `BAF_PERIOD_RST;
            shift_q   <= `BAF_SHIFT_RST;
            range_q   <= 2'h0;
            fen_q     <= {`BAF_NCH{1'b0}};
            fsel_q    <= {(2*`BAF_NCH){1'b0}};
            od_busy_q <= 1'b0;
            od_done_q <= 1'b0;
            ovr_q     <= 1'b0;
            od_data_q <= {NW{1'b0}};
        end else begin
            if (wr_ok && paddr == `BAF_OFF_CTRL) begin
                en_q  <= pwdata[`BAF_CTRL_EN];
                arm_q <= pwdata[`BAF_CTRL_ARM];
            end
            if (wr_ok && paddr == `BAF_OFF_PERIOD) begin
                period_q <= pwdata[23:0];
            end
            if (wr_ok && paddr == `BAF_OFF_CONF) begin
                shift_q <= pwdata[`BAF_CONF_SH_LSB +: 5];
                range_q <= pwdata[`BAF_CONF_RNG_LSB +: 2];
            end
            if (wr_ok && paddr == `BAF_OFF_FILT) begin
                fen_q  <= pwdata[`BAF_NCH-1:0];
                fsel_q <= pwdata[`BAF_FILT_SEL_LSB +: 2*`BAF_NCH];
            end
            if (od_rel) begin
                od_busy_q <= 1'b0;
                od_data_q <= head[NW-1:0];
            end else if (od_req) begin
                od_busy_q <= 1'b1;
            end
            od_done_q <= od_rel | (od_done_q & ~(clr_st & pwdata[`BAF_ST_OD_DONE]));
            ovr_q <= ovr_set | (ovr_q & ~(clr_st & pwdata[`BAF_ST_OVR]));
        end
    end

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0;
        end else if (setup) begin
            case (paddr)
                `BAF_OFF_CTRL:    prdata <= {30'h0, arm_q, en_q};
                `BAF_OFF_PERIOD:  prdata <= {8'h0, period_q};
                `BAF_OFF_CONF:    prdata <= {22'h0, range_q, 3'h0, shift_q};
                `BAF_OFF_FILT:    prdata <= {16'h0, fsel_q, 4'h0, fen_q};
                `BAF_OFF_STATUS:  prdata <= {27'h0, loose, ovr_q, od_done_q,
                                             od_busy_q, trig_q};
                `BAF_OFF_LATENCY: prdata <= lat_q;
                8'h18:            prdata <= {8'h0, lane(od_data_q, 0)};
                8'h1c:            prdata <= {8'h0, lane(od_data_q, 1)};
                8'h20:            prdata <= {8'h0, lane(od_data_q, 2)};
                8'h24:            prdata <= {8'h0, lane(od_data_q, 3)};
                default:          prdata <= 32'h0;
            endcase
        end
    end
endmodule // baf_top

`default_nettype wire

// file: verilog/baf_map.vh
// Purpose: Register offsets, field positions, reset values and timing counts
//          of the buffered acquisition filter block.
// Assumes: pclk at 10 MHz.
// Notes:   Offsets are byte addresses on a 32-bit APB bus.
`ifndef BAF_MAP_VH
`define BAF_MAP_VH

// ==========================================================================
// Register offsets
`define BAF_OFF_CTRL      8'h00
`define BAF_OFF_PERIOD    8'h04
`define BAF_OFF_CONF      8'h08
`define BAF_OFF_FILT      8'h0c
`define BAF_OFF_STATUS    8'h10
`define BAF_OFF_LATENCY   8'h14
`define BAF_OFF_OD_DATA0  8'h18
`define BAF_OD_DATA_LAST  8'h24

// ==========================================================================
// Field positions
`define BAF_CTRL_EN       0
`define BAF_CTRL_ARM      1
`define BAF_CTRL_OD_REQ   2
`define BAF_CONF_SH_LSB   0
`define BAF_CONF_RNG_LSB  8
`define BAF_FILT_SEL_LSB  8
`define BAF_ST_TRIG       0
`define BAF_ST_OD_BUSY    1
`define BAF_ST_OD_DONE    2
`define BAF_ST_OVR        3
`define BAF_ST_LOOSE      4

// ==========================================================================
// Reset values
`define BAF_PERIOD_RST    24'h0000c3
`define BAF_SHIFT_RST     5'h00

// ==========================================================================
// Geometry
`define BAF_NCH           4
`define BAF_DW            24
`define BAF_RING_AW       6

// ==========================================================================
// Timing
`define BAF_CLK_HZ        10000000
`define BAF_CLK_NS        100
`define BAF_MAX_RATE_SPS  51200
`define BAF_LOOSE_HZ      25
`define BAF_FIX_DLY_NS    1797420
`define BAF_LOOSE_FIX_NS  200000
`define BAF_AIN_10V_NS    6770
`define BAF_AIN_OTH_NS    6770
`define BAF_HALF_SMP_NUM  97
`define BAF_MAX_PERIOD    (`BAF_CLK_HZ / `BAF_MAX_RATE_SPS)
`define BAF_LOOSE_PERIOD  (`BAF_CLK_HZ / `BAF_LOOSE_HZ)
`define BAF_FIX_DLY_CYC   ((`BAF_FIX_DLY_NS + `BAF_CLK_NS - 1) / `BAF_CLK_NS)
`define BAF_LOOSE_FIX_CYC ((`BAF_LOOSE_FIX_NS + `BAF_CLK_NS - 1) / `BAF_CLK_NS)
`define BAF_AIN_10V_CYC   ((`BAF_AIN_10V_NS + `BAF_CLK_NS - 1) / `BAF_CLK_NS)
`define BAF_AIN_OTH_CYC   ((`BAF_AIN_OTH_NS + `BAF_CLK_NS - 1) / `BAF_CLK_NS)

`endif

// file: verilog/baf_iir.v
// Purpose: Optional per-channel lowpass stage with a selectable cut-off.
// Assumes: One input strobe per decimated sample.
// Notes:   Four cascaded first-order sections give a fourth-order rolloff.
`timescale 1ns/1ps
`default_nettype none
`include "baf_map.vh"

module baf_iir (
    input  wire                    pclk,
    input  wire                    presetn,
    input  wire                    stb,
    input  wire                    en,
    input  wire [1:0]              sel,
    input  wire [`BAF_DW-1:0]      x,
    output reg  [`BAF_DW-1:0]      y_q,
    output reg                     ystb_q
);
    reg signed [31:0] s_q [0:3];
    wire        [4:0] k = {3'h0, sel} + 5'h02;
    integer           i;

    function signed [31:0] step;
        input signed [31:0] s;
        input signed [31:0] in;
        input        [4:0]  sh;
        begin
            step = s + ((in - s) >>> sh);
        end
    endfunction

    // ======================================================================
    // Filter sections
    // The stage always runs so that enabling it only changes the output
    // select; software still waits for it to settle before starting.
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (i = 0; i < 4; i = i + 1) begin
                s_q[i] <= 32'h0;
            end
            y_q    <= {`BAF_DW{1'b0}};
            ystb_q <= 1'b0;
        end else begin
            ystb_q <= stb;
            if (stb) begin
                s_q[0] <= step(s_q[0], {{4{x[`BAF_DW-1]}}, x, 4'h0}, k);
                for (i = 1; i < 4; i = i + 1) begin
                    s_q[i] <= step(s_q[i], s_q[i-1], k);
                end
                y_q <= en ? s_q[3][27:4] : x;
            end
        end
    end
endmodule // baf_iir

`default_nettype wire

// file: tb/baf_chk.sv
// Purpose: Port-level assertions for the buffered acquisition filter.
// Assumes: One pclk domain, presetn asynchronous and active low.
// Notes:   Attached by bind from the bench top file.
`timescale 1ns/1ps
`default_nettype none
`include "baf_map.vh"

module baf_chk #(
    parameter [31:0] FIX_DLY_CYC   = 32'h00000032,
    parameter [31:0] LOOSE_FIX_CYC = 32'h00000014
) (
    input wire logic        pclk,
    input wire logic        presetn,
    input wire logic        psel,
    input wire logic        penable,
    input wire logic        pwrite,
    input wire logic [7:0]  paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic        pready,
    input wire logic        pslverr,
    input wire logic        adc_valid,
    input wire logic [95:0] adc_data,
    input wire logic        start_trig,
    input wire logic        samp_clk_out,
    input wire logic        trig_out,
    input wire logic        out_valid,
    input wire logic        out_first,
    input wire logic [95:0] out_data
);
    logic bad_addr;
    logic trig_seen_q;
    logic trig_seen_d;

    assign bad_addr    = (paddr > 8'h24) || (paddr[1:0] != 2'h0);
    assign trig_seen_d = out_first ? 1'b0 : (trig_out ? 1'b1 : trig_seen_q);

    // A first point is legal only while a trigger is still waiting for it.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            trig_seen_q <= 1'b0;
        end else begin
            trig_seen_q <= trig_seen_d;
        end
    end

    // ====================
    // Properties
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence s_access;
        psel && penable;
    endsequence
    sequence s_point;
        trig_out && samp_clk_out;
    endsequence

    AST_PREADY: assert property (pready)
        else $error("pready low");
    AST_SLVERR: assert property (s_access |-> pslverr == bad_addr)
        else $error("pslverr does not match the address");
    AST_RD_ZERO: assert property (s_access |-> pwrite || !bad_addr || prdata == 32'h0)
        else $error("unmapped read returned data");
    AST_TRIG_CLK: assert property (trig_out |-> samp_clk_out)
        else $error("trigger output without sample clock");
    AST_TRIG_ONCE: assert property (s_point |=> (!trig_out)[*4])
        else $error("trigger output repeated");
    AST_FIRST_VALID: assert property (out_first |-> out_valid)
        else $error("first point without valid");
    AST_FIRST_TRIG: assert property (out_first |-> trig_seen_q)
        else $error("first point without a trigger");
    AST_SCLK_PULSE: assert property (samp_clk_out |=> !samp_clk_out)
        else $error("sample clock wider than one cycle");
    AST_VALID_PULSE: assert property (out_valid |=> !out_valid)
        else $error("valid wider than one cycle");
    AST_HOLD: assert property (!out_valid |-> $stable(out_data))
        else $error("output data changed without valid");
endmodule // baf_chk
`default_nettype wire

// file: tb/baf_host_model.sv
// Purpose: Host side of the filtered sample stream.
// Assumes: The stream has no back pressure; the host takes every word.
// Notes:   Counts returned points and first-point marks for the bench.
`timescale 1ns/1ps
`default_nettype none

module baf_host_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        out_valid,
    input  wire logic        out_first,
    output logic      [15:0] rx_count,
    output logic      [15:0] first_count
);
    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_count    <= 16'h0;
            first_count <= 16'h0;
        end else if (out_valid) begin
            rx_count    <= rx_count + 16'h1;
            first_count <= first_count + {15'h0, out_first};
        end
    end
endmodule // baf_host_model
`default_nettype wire

// file: tb/tb.sv
// Purpose: Self-checking bench for the buffered acquisition filter.
// Assumes: Shortened fixed delays of 50 and 20 cycles.
// Notes:   Registers are reached by APB tasks; samples by stream waits.
`timescale 1ns/1ps
`default_nettype none
`include "baf_map.vh"

module tb;
    localparam [31:0] FIX  = 32'h00000032;
    localparam [31:0] LFIX = 32'h00000014;
    localparam [23:0] C    = 24'h000100;
    logic        pclk, presetn, psel, penable, pwrite, adc_valid, start_trig;
    logic [7:0]  paddr;
    logic [31:0] pwdata, rd_q;
    logic [95:0] adc_data;
    logic        slv_q;
    wire  [31:0] prdata;
    wire  [95:0] out_data;
    wire         pready, pslverr, samp_clk_out, trig_out, out_valid, out_first;
    wire  [15:0] rx_count, first_count;
    int          err_count = 0;
    int          n_compared = 0;
    int          cyc = 0;

    baf_top #(.FIX_DLY_CYC(FIX), .LOOSE_FIX_CYC(LFIX)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .adc_valid(adc_valid),
        .adc_data(adc_data), .start_trig(start_trig), .samp_clk_out(samp_clk_out),
        .trig_out(trig_out), .out_valid(out_valid), .out_first(out_first),
        .out_data(out_data));
    baf_host_model host (.pclk(pclk), .presetn(presetn), .out_valid(out_valid),
        .out_first(out_first), .rx_count(rx_count), .first_count(first_count));

    // ====================
    // Tasks
    function automatic logic [31:0] lat_exp(input logic [31:0] p);
        return ((p > 32'h00061a80) ? LFIX : FIX) + ((p * 32'h61) >> 1) + 32'h44;
    endfunction

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    task automatic timeout_stop;
        err_count++;
        $display("mismatch wait expected event seen timeout");
        report_and_stop();
    endtask

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    // The request stays put until pready is seen high; one idle cycle follows.
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel   <= 1'b1;
        pwrite <= wr;
        paddr  <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 16);
        if (n >= 16) timeout_stop();
        rd_q = prdata;
        slv_q = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(nm, rd_q, exp);
    endtask

    task automatic wait_for(input int s, output int n);
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while ((s == 0 ? out_valid : s == 1 ? trig_out : out_first) !== 1'b1 && n < 4000);
        if (n >= 4000) timeout_stop();
    endtask

    // ====================
    // Sequence
    initial begin
        pclk = 1'b0;
        forever #50 pclk = ~pclk;
    end

    always @(posedge pclk) cyc <= cyc + 1;

    initial begin
        int n;
        int t0;
        logic [31:0] pers [4];
        pers = '{32'h2, 32'h00061a80, 32'h00061a81, 32'h8};
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h0;
        pwdata = 32'h0;
        adc_valid = 1'b0;
        start_trig = 1'b0;
        adc_data = {4{C}};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        adc_valid <= 1'b1;
        @(posedge pclk);
        rd_chk("ctrl", `BAF_OFF_CTRL, 32'h0);
        rd_chk("period", `BAF_OFF_PERIOD, 32'h000000c3);
        rd_chk("conf", `BAF_OFF_CONF, 32'h0);
        rd_chk("filt", `BAF_OFF_FILT, 32'h0);
        rd_chk("status", `BAF_OFF_STATUS, 32'h0);
        rd_chk("latency", `BAF_OFF_LATENCY, lat_exp(32'hc3));
        rd_chk("unmapped", 8'h28, 32'h0);
        chk("slverr", {31'h0, slv_q}, 32'h1);
        apb(1'b1, `BAF_OFF_LATENCY, 32'h00001234);
        rd_chk("latency ro", `BAF_OFF_LATENCY, lat_exp(32'hc3));
        $display("test registers done");
        foreach (pers[i]) begin
            apb(1'b1, `BAF_OFF_PERIOD, pers[i]);
            rd_chk("latency", `BAF_OFF_LATENCY, lat_exp(pers[i]));
            apb(1'b0, `BAF_OFF_STATUS, 32'h0);
            chk("loose", {31'h0, rd_q[`BAF_ST_LOOSE]}, {31'h0, pers[i] > 32'h00061a80});
        end
        $display("test latency done");
        apb(1'b1, `BAF_OFF_CONF, 32'h3);
        apb(1'b1, `BAF_OFF_FILT, 32'h00000402);
        rd_chk("filt", `BAF_OFF_FILT, 32'h00000402);
        // Settling pause after a lowpass is switched on, before the run starts.
        repeat (20) @(posedge pclk);
        apb(1'b1, `BAF_OFF_CTRL, 32'h3);
        start_trig <= 1'b1;
        wait_for(1, n);
        start_trig <= 1'b0;
        wait_for(2, n);
        chk("group delay", n, lat_exp(32'h8));
        chk("first index", {16'h0, rx_count}, 32'h0);
        chk("lowpass ch1", {31'h0, out_data[47:24] !== C}, 32'h1);
        wait_for(0, n);
        wait_for(0, n);
        chk("ch0", {8'h0, out_data[23:0]}, {8'h0, C});
        $display("test stream done");
        apb(1'b1, `BAF_OFF_PERIOD, 32'h10);
        apb(1'b1, `BAF_OFF_CONF, 32'h4);
        rd_chk("latency", `BAF_OFF_LATENCY, lat_exp(32'h10));
        repeat (72) wait_for(0, n);
        chk("ch0 rate", {8'h0, out_data[23:0]}, {8'h0, C});
        rd_chk("status", `BAF_OFF_STATUS, 32'h1);
        chk("first count", {16'h0, first_count}, 32'h1);
        $display("test rate done");
        apb(1'b1, `BAF_OFF_CTRL, 32'h0);
        apb(1'b1, `BAF_OFF_CONF, 32'h0);
        adc_data <= {4{24'h000001}};
        apb(1'b1, `BAF_OFF_CTRL, 32'h4);
        t0 = cyc;
        apb(1'b0, `BAF_OFF_STATUS, 32'h0);
        chk("od busy", {31'h0, rd_q[`BAF_ST_OD_BUSY]}, 32'h1);
        n = 0;
        do begin
            apb(1'b0, `BAF_OFF_STATUS, 32'h0);
            n++;
        end while (rd_q[`BAF_ST_OD_DONE] !== 1'b1 && n < 6000);
        if (n >= 6000) timeout_stop();
        chk("od wait", {31'h0, (cyc - t0) >= lat_exp(32'hc3)}, 32'h1);
        rd_chk("od data", `BAF_OFF_OD_DATA0, 32'h000000c3);
        apb(1'b1, `BAF_OFF_STATUS, 32'h4);
        apb(1'b0, `BAF_OFF_STATUS, 32'h0);
        chk("od done clear", {31'h0, rd_q[`BAF_ST_OD_DONE]}, 32'h0);
        $display("test on demand done");
        report_and_stop();
    end
endmodule // tb

bind baf_top baf_chk #(.FIX_DLY_CYC(FIX_DLY_CYC), .LOOSE_FIX_CYC(LOOSE_FIX_CYC)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .adc_valid(adc_valid),
    .adc_data(adc_data), .start_trig(start_trig), .samp_clk_out(samp_clk_out),
    .trig_out(trig_out), .out_valid(out_valid), .out_first(out_first),
    .out_data(out_data));
`default_nettype wire
